// >>> rtl/mssc_top.sv
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module mssc_top #(
   parameter int POWERUP_CYCLES = 625000000,
   parameter int MS_TICKS       = 125000,
   parameter int TRANSIENT_MS   = 2000,
   parameter int LOOP_TIMEOUT   = 1000000
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Trigger pins and bus events
   input  wire logic        ext_trigger,
   input  wire logic        key_trigger,
   input  wire logic        talk_trigger,
   input  wire logic        get_trigger,
   input  wire logic        exec_char,
   input  wire logic        remote_state,
   input  wire logic        bad_command,
   input  wire logic        bad_option,
   input  wire logic        key_press,
   // Storage and self test
   input  wire logic        stored_master,
   input  wire logic        setup_checksum_bad,
   input  wire logic [6:0]  setup_checksum_loc,
   input  wire logic        card_checksum_bad,
   input  wire logic [7:0]  hardware_settle_interval,
   // Serial loop
   input  wire logic        loop_all_powered,
   input  wire logic        loop_closed,
   input  wire logic        loop_line_error,
   // Outputs to relays and storage
   output logic             relays_open_all,
   output logic             relay_load,
   output logic [8:0]       relay_load_loc,
   output logic             setup_clear,
   output logic [6:0]       setup_clear_loc,
   output logic             clear_all_setups,
   output logic [7:0]       digital_output,
   output logic             matrix_ready,
   output logic             serial_ready,
   output logic             is_master,
   output logic             persistent_msg,
   output logic             transient_msg
);
   // ============================================================
   // State
   typedef struct packed {
      mssc_pkg::mssc_state_type st;
      logic [31:0] cnt;
      logic [15:0] ms_left;
      logic [16:0] ms_tick;
      logic [11:0] tr_ms;
      logic        tr_act;
      logic        pers;
      logic [8:0]  relay_step;
      logic [8:0]  memory_step;
      logic        show_relays;
      logic        trig_en;
      logic [2:0]  trig_src;
      logic        rise_edge;
      logic        rdy_high;
      logic [7:0]  digout;
      logic [15:0] prog_delay;
      logic [4:0]  bus_addr;
      logic [7:0]  mb_rows;
      logic [7:0]  bm_rows;
      logic        master;
      logic        opened;
      logic [mssc_pkg::ERR_W-1:0] err;
      logic [2:0]  e1;
      logic [2:0]  e2;
      logic        e3;
      logic        ld;
      logic        clr_all;
      logic        sclr;
      logic [6:0]  sclr_loc;
      logic [31:0] rd;
      logic        pulse;
   } mssc_reg_type;

   mssc_reg_type r;
   mssc_reg_type next_r;

   // Synchronised pin levels (stage 2 and the delayed copy e3 are read)
   logic ext_now;
   logic ext_prev;
   logic acc;
   logic do_write;
   logic do_read;
   logic [mssc_pkg::ERR_W-1:0] ev;
   logic                       trig;

   assign acc      = psel & penable;
   assign do_write = acc & pwrite;
   assign do_read  = acc & ~pwrite;
   assign ext_now  = r.e2[0];
   assign ext_prev = r.e3;

   // ============================================================
   // Trigger selection
   always_comb
   begin
      unique case (r.trig_src)
         mssc_pkg::SRC_EXT:  trig = r.rise_edge ? (ext_now & ~ext_prev) : (~ext_now & ext_prev);
         mssc_pkg::SRC_KEY:  trig = key_trigger;
         mssc_pkg::SRC_TALK: trig = talk_trigger;
         mssc_pkg::SRC_GET:  trig = get_trigger;
         mssc_pkg::SRC_EXEC: trig = exec_char & remote_state;
         default:            trig = 1'b0;
      endcase
      trig = trig & r.trig_en & (r.st != mssc_pkg::ST_POWERUP);
   end

   // ============================================================
   // Next state
   always_comb
   begin
      next_r       = r;
      next_r.e1    = {loop_all_powered, 1'b0, ext_trigger};
      next_r.e2    = r.e1;
      next_r.e3    = r.e2[0];
      next_r.ld    = 1'b0;
      next_r.sclr  = 1'b0;
      next_r.clr_all = 1'b0;
      next_r.pulse = 1'b0;
      ev           = '0;
      ev[mssc_pkg::ERR_LOOP]   = loop_line_error;
      ev[mssc_pkg::ERR_REMOTE] = exec_char & ~remote_state;
      ev[mssc_pkg::ERR_BADCMD] = bad_command;
      ev[mssc_pkg::ERR_BADOPT] = bad_option;
      ev[mssc_pkg::ERR_CARDID] = card_checksum_bad;
      ev[mssc_pkg::ERR_LOOPDN] = ~r.e2[2];
      // Millisecond tick divider
      next_r.ms_tick = (r.ms_tick == 17'(MS_TICKS - 1)) ? 17'h00000 : r.ms_tick + 17'h00001;
      unique case (r.st)
         mssc_pkg::ST_POWERUP:
         begin
            next_r.cnt = r.cnt + 32'h00000001;
            if (setup_checksum_bad)
            begin
               next_r.sclr     = 1'b1;
               next_r.sclr_loc = setup_checksum_loc;
               ev[mssc_pkg::ERR_SETUP] = 1'b1;
            end
            if (r.cnt >= 32'(POWERUP_CYCLES - 1))
               next_r.st = mssc_pkg::ST_WAITLP;
         end
         mssc_pkg::ST_WAITLP:
            // defer until loop powered; non-master stand-alone
            if (r.e2[2])
            begin
               next_r.cnt = '0;
               next_r.st  = stored_master ? mssc_pkg::ST_LOOPEST : mssc_pkg::ST_IDLE;
            end
         mssc_pkg::ST_LOOPEST:
         begin
            next_r.cnt = r.cnt + 32'h00000001;
            if (loop_closed)
            begin
               next_r.master = 1'b1;
               next_r.st     = mssc_pkg::ST_IDLE;
            end
            else if (r.cnt >= 32'(LOOP_TIMEOUT - 1))
            begin
               next_r.master = 1'b0;
               ev[mssc_pkg::ERR_LOOP] = 1'b1;
               next_r.st     = mssc_pkg::ST_IDLE;
            end
         end
         mssc_pkg::ST_IDLE:
            if (trig)
            begin
               next_r.relay_step = (r.relay_step == mssc_pkg::STEP_LAST) ? 9'h000 : r.relay_step + 9'h001;
               next_r.ld         = 1'b1;
               next_r.opened     = 1'b0;
               next_r.st         = mssc_pkg::ST_SWITCH;
            end
         mssc_pkg::ST_SWITCH:
         begin
            next_r.ms_left = r.prog_delay + {8'h00, hardware_settle_interval};
            next_r.st      = mssc_pkg::ST_SETTLE;
            if (trig)
               ev[mssc_pkg::ERR_OVERRUN] = 1'b1;
         end
         mssc_pkg::ST_SETTLE:
         begin
            if (r.ms_tick == 17'h00000 && r.ms_left != 16'h0000)
               next_r.ms_left = r.ms_left - 16'h0001;
            if (trig)
            begin
               ev[mssc_pkg::ERR_OVERRUN] = 1'b1;
               ev[mssc_pkg::ERR_EARLY]   = 1'b1;
               next_r.relay_step = (r.relay_step == mssc_pkg::STEP_LAST) ? 9'h000 : r.relay_step + 9'h001;
               next_r.ld         = 1'b1;
               next_r.st         = mssc_pkg::ST_SWITCH;
            end
            else if (r.ms_left == 16'h0000)
            begin
               next_r.pulse = 1'b1;
               next_r.st    = mssc_pkg::ST_IDLE;
            end
         end
         default: next_r.st = mssc_pkg::ST_IDLE;
      endcase
      if (|ev[mssc_pkg::ERR_REMOTE:mssc_pkg::ERR_OVERRUN] | ev[mssc_pkg::ERR_BADOPT] | ev[mssc_pkg::ERR_BADCMD])
      begin
         next_r.tr_act = 1'b1;
         next_r.tr_ms  = 12'(TRANSIENT_MS);
      end
      else if (r.tr_act && r.ms_tick == 17'h00000)
      begin
         next_r.tr_ms  = r.tr_ms - 12'h001;
         next_r.tr_act = (r.tr_ms > 12'h001);
      end
      if (ev[mssc_pkg::ERR_LOOP] | ev[mssc_pkg::ERR_SETUP] | ev[mssc_pkg::ERR_CARDID])
         next_r.pers = 1'b1;
      else if (key_press | do_write)
         next_r.pers = 1'b0;
      // APB register writes
      if (do_write)
         unique case (paddr)
            mssc_pkg::ADDR_CTRL:
            begin
               next_r.trig_en = pwdata[0];
               if (pwdata[1])
               begin
                  next_r.cnt = '0;
                  next_r.st  = mssc_pkg::ST_LOOPEST;
               end
               if (pwdata[2])
               begin
                  next_r.clr_all  = 1'b1;
                  next_r.bus_addr = mssc_pkg::BUS_ADDR_FACTORY;
                  next_r.mb_rows  = '0;
                  next_r.bm_rows  = '0;
               end
               if (pwdata[2] | pwdata[3])
               begin
                  next_r.relay_step  = mssc_pkg::RELAY_STEP_RESET;
                  next_r.memory_step = mssc_pkg::MEMORY_STEP_RESET;
                  next_r.show_relays = 1'b1;
                  next_r.digout      = mssc_pkg::DIGOUT_RESET;
                  next_r.prog_delay  = '0;
                  next_r.trig_src    = mssc_pkg::SRC_EXT;
                  next_r.rise_edge   = 1'b0;
                  next_r.rdy_high    = 1'b0;
                  next_r.trig_en     = 1'b0;
                  next_r.opened      = 1'b1;
               end
            end
            mssc_pkg::ADDR_CONFIG:
            begin
               next_r.trig_src  = pwdata[2:0];
               next_r.rise_edge = pwdata[3];
               next_r.rdy_high  = pwdata[4];
               next_r.digout    = pwdata[15:8];
               next_r.bus_addr  = pwdata[20:16];
            end
            mssc_pkg::ADDR_DELAY:    next_r.prog_delay = pwdata[15:0];
            mssc_pkg::ADDR_POINTERS:
            begin
               next_r.memory_step = pwdata[24:16];
               next_r.show_relays = pwdata[31];
            end
            mssc_pkg::ADDR_ROWS:
            begin
               next_r.mb_rows = pwdata[7:0] & ~pwdata[15:8];
               next_r.bm_rows = pwdata[15:8];
            end
            default: ;
         endcase
      // Sticky errors, loop-down bit live: write-one-to-clear, set wins
      if (do_write && paddr == mssc_pkg::ADDR_ERRORS)
         next_r.err = r.err & ~pwdata[mssc_pkg::ERR_W-1:0];
      next_r.err = next_r.err | ev;
      next_r.err[mssc_pkg::ERR_LOOPDN] = ~r.e2[2];
      // Read data
      next_r.rd = 32'h00000000;
      if (psel & ~penable & ~pwrite)
         unique case (paddr)
            mssc_pkg::ADDR_CTRL:     next_r.rd = {31'h0, r.trig_en};
            mssc_pkg::ADDR_CONFIG:   next_r.rd = {11'h0, r.bus_addr, r.digout, 3'h0, r.rdy_high,
                                                  r.rise_edge, r.trig_src};
            mssc_pkg::ADDR_DELAY:    next_r.rd = {16'h0, r.prog_delay};
            mssc_pkg::ADDR_STATUS:   next_r.rd = {18'h0, r.pers, r.tr_act, r.master, r.show_relays,
                                                  r.st == mssc_pkg::ST_IDLE, r.st, r.e2[2], r.opened, 1'b0};
            mssc_pkg::ADDR_POINTERS: next_r.rd = {r.show_relays, 6'h0, r.memory_step, 7'h0, r.relay_step};
            mssc_pkg::ADDR_ERRORS:   next_r.rd = {23'h0, r.err};
            mssc_pkg::ADDR_ROWS:     next_r.rd = {16'h0, r.bm_rows, r.mb_rows};
            default:                 next_r.rd = 32'h00000000;
         endcase
   end

   // ============================================================
   // Registers
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         // pointers and display source; open, disabled
         r             <= '0;
         r.st          <= mssc_pkg::ST_POWERUP;
         r.relay_step  <= mssc_pkg::RELAY_STEP_RESET;
         r.memory_step <= mssc_pkg::MEMORY_STEP_RESET;
         r.show_relays <= 1'b1;
         r.opened      <= 1'b1;
         r.bus_addr    <= mssc_pkg::BUS_ADDR_FACTORY;
         r.e1          <= 3'h1;
         r.e2          <= 3'h1;
         r.e3          <= 1'b1;
      end
      else
         r <= next_r;
   end

   // ============================================================
   // Outputs
   assign prdata           = r.rd;
   assign pready           = 1'b1;
   assign pslverr          = 1'b0;
   assign relays_open_all  = r.opened;
   assign relay_load       = r.ld;
   assign relay_load_loc   = r.relay_step;
   assign setup_clear      = r.sclr;
   assign setup_clear_loc  = r.sclr_loc;
   assign clear_all_setups = r.clr_all;
   assign digital_output   = r.digout;
   assign matrix_ready     = r.pulse ^ ~r.rdy_high;
   assign serial_ready     = (r.st == mssc_pkg::ST_IDLE);
   assign is_master        = r.master;
   assign persistent_msg   = r.pers;
   assign transient_msg    = r.tr_act;

   // ============================================================
   // Checks
   property p_reset_ptr;
      @(posedge mclk) $fell(rst) |-> r.relay_step == 9'h000 && r.memory_step == 9'h001;
   endproperty
   a_reset_ptr: assert property (p_reset_ptr) else $error("pointers wrong after reset");
   property p_no_trig_pu;
      @(posedge mclk) disable iff (rst) r.st == mssc_pkg::ST_POWERUP |-> !relay_load;
   endproperty
   a_no_trig_pu: assert property (p_no_trig_pu) else $error("load during power-up");
   property p_step;
      @(posedge mclk) disable iff (rst) (trig && r.st == mssc_pkg::ST_IDLE && r.relay_step < 9'h064)
         |=> relay_load && relay_load_loc == $past(r.relay_step) + 9'h001;
   endproperty
   a_step: assert property (p_step) else $error("wrong step sent");
   property p_overrun;
      @(posedge mclk) disable iff (rst) (trig && r.st == mssc_pkg::ST_SETTLE) |=> r.err[1] && r.err[2];
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged");
   property p_remote;
      @(posedge mclk) disable iff (rst) (exec_char && !remote_state) |=> r.err[3] && !relay_load;
   endproperty
   a_remote: assert property (p_remote) else $error("not-remote missed");
   property p_cmd;
      @(posedge mclk) disable iff (rst) bad_option |=> r.err[5];
   endproperty
   a_cmd: assert property (p_cmd) else $error("option fault missed");
   property p_ready;
      @(posedge mclk) disable iff (rst) (r.st == mssc_pkg::ST_SETTLE && r.ms_left == 16'h0000 && !trig)
         |=> matrix_ready == r.rdy_high;
   endproperty
   a_ready: assert property (p_ready) else $error("ready polarity wrong");
   property p_wait;
      @(posedge mclk) disable iff (rst) (r.st == mssc_pkg::ST_WAITLP && !r.e2[2]) |=> r.st == mssc_pkg::ST_WAITLP;
   endproperty
   a_wait: assert property (p_wait) else $error("left wait without power");
   c_trig: cover property (@(posedge mclk) relay_load);
   c_early: cover property (@(posedge mclk) r.err[2]);
   c_master: cover property (@(posedge mclk) $rose(r.master));
endmodule

// >>> rtl/mssc_pkg.sv
// What this block does
// - Reset: relay pointer 000, memory pointer 001
// - Power-up: relays open, triggering disabled
// - Reset: output 000, delay 0, falling, low
// - Factory init clears setups, address 18, rows
// - Power-up sequence finishes in about five seconds
// - Report loop down, wait for all powered
// - Stored stand-alone or slave: come up stand-alone
// - Stored master: try loop, else error, stand-alone
// - Master selected: start loop, leave menu
// - Trigger sends setup at relay pointer plus one
// - Memory pointer holds last recalled setup
// - Fourteen-character display, six-digit scratchpad
// - Transient errors two seconds, persistent until operation
// - Flag loop communication errors of any kind
// - Flag trigger before completion as overflow
// - Early trigger raises notice, still processed
// - Settle delay is programmed plus hardware interval
// - Five selectable trigger sources
// - Selectable trigger edge and completion polarity
// - Execute character when not remote: error
// - Separate bad command and bad option faults
// - Setup checksum failure clears setup, continues
package mssc_pkg;
   // APB register byte addresses
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_CONFIG   = 8'h04;
   localparam logic [7:0] ADDR_DELAY    = 8'h08;
   localparam logic [7:0] ADDR_STATUS   = 8'h0C;
   localparam logic [7:0] ADDR_POINTERS = 8'h10;
   localparam logic [7:0] ADDR_ERRORS   = 8'h14;
   localparam logic [7:0] ADDR_ROWS     = 8'h18;
   localparam logic [7:0] ADDR_EVENT    = 8'h1C;
   // Reset values
   localparam logic [8:0] RELAY_STEP_RESET  = 9'h000;
   localparam logic [8:0] MEMORY_STEP_RESET = 9'h001;
   localparam logic [8:0] STEP_LAST         = 9'h064;
   localparam logic [7:0] DIGOUT_RESET      = 8'h00;
   localparam logic [4:0] BUS_ADDR_FACTORY  = 5'h12;
   localparam logic [2:0] MAX_UNITS         = 3'h5;
   // Trigger sources
   localparam logic [2:0] SRC_EXT  = 3'h0;
   localparam logic [2:0] SRC_KEY  = 3'h1;
   localparam logic [2:0] SRC_TALK = 3'h2;
   localparam logic [2:0] SRC_GET  = 3'h3;
   localparam logic [2:0] SRC_EXEC = 3'h4;
   // Error bit positions
   localparam int ERR_LOOP    = 0;
   localparam int ERR_OVERRUN = 1;
   localparam int ERR_EARLY   = 2;
   localparam int ERR_REMOTE  = 3;
   localparam int ERR_BADCMD  = 4;
   localparam int ERR_BADOPT  = 5;
   localparam int ERR_SETUP   = 6;
   localparam int ERR_CARDID  = 7;
   localparam int ERR_LOOPDN  = 8;
   localparam int ERR_W       = 9;
   // Timing
   localparam longint CLK_HZ          = 125000000;
   localparam longint MS_TICKS        = CLK_HZ / 1000;
   localparam longint POWERUP_MS      = 5000;
   localparam longint TRANSIENT_MS    = 2000;
   localparam longint POWERUP_CYCLES  = POWERUP_MS * MS_TICKS;
   localparam longint TRANSIENT_MS_W  = TRANSIENT_MS;
   localparam int     MS_TICKS_I      = int'(MS_TICKS);
   localparam int DISPLAY_CHARS  = 14;
   localparam int SCRATCH_DIGITS = 6;
   // Control states
   typedef enum logic [5:0] {
      ST_POWERUP = 6'h01,
      ST_WAITLP  = 6'h02,
      ST_LOOPEST = 6'h04,
      ST_IDLE    = 6'h08,
      ST_SWITCH  = 6'h10,
      ST_SETTLE  = 6'h20
   } mssc_state_type;
endpackage

// >>> tb/mssc_loop_model.sv
`timescale 1ns/1ps
// ==================================================
// Far end: the other mainframes of the serial ring
module mssc_loop_model #(
   parameter int UNITS = 5
) (
   // Clock
   input  wire logic       mclk,
   // Bench controls of the far units
   input  wire logic [2:0] powered_cnt,
   input  wire logic       ring_wired,
   input  wire logic       line_fault,
   // Loop status seen by the unit
   output logic            loop_all_powered,
   output logic            loop_closed,
   output logic            loop_line_error
);
   // Status moves just after an edge, as a real receiver reports it
   always_ff @(posedge mclk)
   begin
      loop_all_powered <= (powered_cnt == 3'(UNITS));
      loop_closed      <= ring_wired && (UNITS <= 5) && (powered_cnt == 3'(UNITS));
      loop_line_error  <= line_fault;
   end
endmodule

// >>> tb/test_matrix_setup_sequencer_control.sv
`timescale 1ns/1ps
// ==================================================
// Self-checking bench of the sequencer control
module test_matrix_setup_sequencer_control;
   // Bench signals
   logic        mclk, rst, psel, penable, pwrite, pready, pslverr, ext_idle, remote_state, ring;
   logic        stored_master, seen_clr, relays_open_all, relay_load, setup_clear, clear_all_setups;
   logic        matrix_ready, serial_ready, is_master, persistent_msg, transient_msg, lp_pwr, lp_cl, lp_err;
   logic [7:0]  paddr, hw, digital_output;
   logic [31:0] pwdata, prdata, q, lfsr;
   logic [10:0] trg;
   logic [6:0]  sloc, clr_loc, got_loc;
   logic [8:0]  relay_load_loc, step;
   logic [2:0]  pwr;
   int          error_cnt, total_checks, n, loads, fired;
   // ==================================================
   // Design and far end
   mssc_top #(.POWERUP_CYCLES(100), .MS_TICKS(10), .TRANSIENT_MS(20), .LOOP_TIMEOUT(50)) dut (
      .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .ext_trigger(ext_idle ^ trg[0]), .key_trigger(trg[1]), .talk_trigger(trg[2]), .get_trigger(trg[3]),
      .exec_char(trg[4]), .remote_state, .bad_command(trg[5]), .bad_option(trg[6]), .key_press(trg[10]),
      .stored_master, .setup_checksum_bad(trg[8]), .setup_checksum_loc(sloc), .card_checksum_bad(trg[9]),
      .hardware_settle_interval(hw), .loop_all_powered(lp_pwr), .loop_closed(lp_cl), .loop_line_error(lp_err),
      .relays_open_all, .relay_load, .relay_load_loc, .setup_clear, .setup_clear_loc(clr_loc),
      .clear_all_setups, .digital_output, .matrix_ready, .serial_ready, .is_master, .persistent_msg,
      .transient_msg);
   mssc_loop_model #(.UNITS(5)) far_end (.mclk, .powered_cnt(pwr), .ring_wired(ring), .line_fault(trg[7]),
      .loop_all_powered(lp_pwr), .loop_closed(lp_cl), .loop_line_error(lp_err));
   // 125 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // One-cycle outputs are recorded so a busy task cannot miss them
   always @(posedge mclk)
   begin
      if (relay_load === 1'b1) loads <= loads + 1;
      if (setup_clear === 1'b1) got_loc <= clr_loc;
      if (clear_all_setups === 1'b1) seen_clr <= 1'b1;
   end
   // ==================================================
   // Expectation and stimulus helpers
   function automatic logic [8:0] step_next(logic [8:0] s);
      return (s == mssc_pkg::STEP_LAST) ? 9'h000 : s + 9'h001;
   endfunction
   function automatic logic [31:0] lfsr_next(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("unexpected %s: expected %0h seen %0h", nm, e, g);
      end
   endtask
   // Request is held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
         @(posedge mclk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, q & m);
   endtask
   task pulse(input int k);
      trg[k] <= 1'b1;
      @(posedge mclk);
      trg[k] <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wait_lvl(input string nm, ref logic s, input logic v, input int lim);
      n = 0;
      while (s !== v && n < lim)
      begin
         @(posedge mclk);
         n++;
      end
      chk(nm, {31'h0, v}, {31'h0, s});
   endtask
   // A polite controller polls ready first; a rude one does not
   task fire(input int k, input logic polite);
      if (polite)
         wait_lvl("serial_ready", serial_ready, 1'b1, 500);
      step = step_next(step);
      fired++;
      pulse(k);
      wait_lvl("relay_load", relay_load, 1'b1, 20);
      chk("relay_load_loc", {23'h0, step}, {23'h0, relay_load_loc});
   endtask
   task finish_test;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ==================================================
   // Main sequence
   initial
   begin
      {rst, ring, ext_idle, remote_state, psel, penable, pwrite, stored_master, seen_clr} = 9'h1E0;
      {paddr, hw, pwdata, trg, sloc, got_loc, step} = 0;
      pwr = 3'h4;
      lfsr = 32'h0001_1889;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      rdc("pointers", mssc_pkg::ADDR_POINTERS, 32'hFFFF_FFFF, 32'h8001_0000);
      chk("relays_open", 32'h1, {31'h0, relays_open_all});
      chk("digital_output", 32'h0, {24'h0, digital_output});
      chk("matrix_ready_idle", 32'h1, {31'h0, matrix_ready});
      rdc("config", mssc_pkg::ADDR_CONFIG, 32'h0000_FF1F, 32'h0);
      rdc("delay", mssc_pkg::ADDR_DELAY, 32'h0000_FFFF, 32'h0);
      repeat (150) @(posedge mclk);
      rdc("loop_down", mssc_pkg::ADDR_ERRORS, 32'h100, 32'h100);
      chk("serial_ready", 32'h0, {31'h0, serial_ready});
      pwr <= 3'h5;
      wait_lvl("serial_ready", serial_ready, 1'b1, 300);
      chk("is_master", 32'h0, {31'h0, is_master});
      pulse(0);
      repeat (8) @(posedge mclk);
      chk("loads", 32'h0, 32'(loads));
      wr(mssc_pkg::ADDR_CTRL, 32'h1);
      // Every source once; external on its default falling edge
      for (int k = 0; k < 5; k++)
      begin
         wr(mssc_pkg::ADDR_CONFIG, 32'(k));
         fire(k, 1'b1);
      end
      // Rising edge only: the falling idle change must be ignored
      wr(mssc_pkg::ADDR_CONFIG, 32'h8);
      ext_idle <= 1'b0;
      repeat (8) @(posedge mclk);
      chk("loads", 32'(fired), 32'(loads));
      fire(0, 1'b1);
      remote_state <= 1'b0;
      wr(mssc_pkg::ADDR_CONFIG, 32'h4);
      pulse(4);
      repeat (20) @(posedge mclk);
      chk("loads", 32'(fired), 32'(loads));
      rdc("not_remote", mssc_pkg::ADDR_ERRORS, 32'h8, 32'h8);
      remote_state <= 1'b1;
      wr(mssc_pkg::ADDR_ERRORS, 32'h0000_01FF);
      pulse(5);
      repeat (165) @(posedge mclk);
      chk("transient_msg", 32'h1, {31'h0, transient_msg});
      repeat (60) @(posedge mclk);
      chk("transient_msg", 32'h0, {31'h0, transient_msg});
      pulse(6);
      pulse(7);
      rdc("errors", mssc_pkg::ADDR_ERRORS, 32'h1FF, 32'h031);
      // Settle of 3 ms programmed plus 2 ms hardware, then a rude trigger
      hw <= 8'h02;
      wr(mssc_pkg::ADDR_DELAY, 32'h3);
      wr(mssc_pkg::ADDR_CONFIG, 32'h11);
      fire(1, 1'b1);
      wait_lvl("matrix_ready", matrix_ready, 1'b1, 400);
      chk("settle_span", 32'h1, 32'(n >= 40 && n <= 56));
      fire(1, 1'b1);
      repeat (10) @(posedge mclk);
      fire(1, 1'b0);
      rdc("overrun_early", mssc_pkg::ADDR_ERRORS, 32'h6, 32'h6);
      chk("transient_msg", 32'h1, {31'h0, transient_msg});
      repeat (120) @(posedge mclk);
      wr(mssc_pkg::ADDR_CTRL, 32'h3);
      wait_lvl("is_master", is_master, 1'b1, 200);
      wr(mssc_pkg::ADDR_ROWS, 32'h0000_0F30);
      for (int i = 0; i < 3; i++)
      begin
         lfsr = lfsr_next(lfsr);
         wr(mssc_pkg::ADDR_CONFIG, {16'h0, lfsr[7:0], 8'h00});
         repeat (2) @(posedge mclk);
         chk("digital_output", {24'h0, lfsr[7:0]}, {24'h0, digital_output});
      end
      wr(mssc_pkg::ADDR_POINTERS, 32'h0005_0000);
      rdc("memory_step", mssc_pkg::ADDR_POINTERS, 32'h81FF_0000, 32'h0005_0000);
      wr(mssc_pkg::ADDR_CTRL, 32'h8);
      repeat (2) @(posedge mclk);
      chk("digital_output", 32'h0, {24'h0, digital_output});
      rdc("rows_kept", mssc_pkg::ADDR_ROWS, 32'hFFFF, 32'h0F30);
      rdc("delay", mssc_pkg::ADDR_DELAY, 32'hFFFF, 32'h0);
      rdc("pointers", mssc_pkg::ADDR_POINTERS, 32'hFFFF_FFFF, 32'h8001_0000);
      wr(mssc_pkg::ADDR_CTRL, 32'h4);
      repeat (2) @(posedge mclk);
      chk("clear_all", 32'h1, {31'h0, seen_clr});
      rdc("rows", mssc_pkg::ADDR_ROWS, 32'hFFFF, 32'h0);
      rdc("bus_addr", mssc_pkg::ADDR_CONFIG, 32'h001F_0000, 32'h0012_0000);
      rdc("unmapped", 8'h24, 32'hFFFF_FFFF, 32'h0);
      // Second power-up: stored master with an open ring, bad setup found
      stored_master <= 1'b1;
      ring <= 1'b0;
      rst <= 1'b1;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      lfsr = lfsr_next(lfsr);
      sloc <= lfsr[6:0];
      @(posedge mclk);
      pulse(8);
      pulse(9);
      wait_lvl("serial_ready", serial_ready, 1'b1, 400);
      chk("is_master", 32'h0, {31'h0, is_master});
      chk("persistent_msg", 32'h1, {31'h0, persistent_msg});
      chk("clear_loc", {25'h0, lfsr[6:0]}, {25'h0, got_loc});
      rdc("errors", mssc_pkg::ADDR_ERRORS, 32'hC1, 32'hC1);
      pulse(10);
      repeat (3) @(posedge mclk);
      chk("persistent_msg", 32'h0, {31'h0, persistent_msg});
      finish_test();
   end
   // Watchdog well beyond the thousand or so cycles the run needs
   initial
   begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      finish_test();
   end
endmodule
